// ==== onw_decoder_assertions.sv ====
// port assertions for the nibble write decoder
`timescale 1ns/100ps
module onw_decoder_checker (
    input wire logic sys_clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic clk_en, // clock enable
    input wire logic cmd_valid, // command strobe
    input wire logic [3:0] cmd_nibble_location, // location
    input wire logic [3:0] cmd_data, // data nibble
    input wire logic [1:0] bank_select, // bank
    input wire logic otp_program_flag, // program flag
    input wire logic resp_valid, // response strobe
    input wire logic [15:0] resp_word, // response word
    input wire logic prog_valid, // program request
    input wire logic [3:0] device_bus_id, // bus identifier
    input wire logic [1:0] filter_select, // filter select
    input wire logic seal_bit // seal bit
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // a command counts only when the enable lets it in
    sequence s_taken;
        cmd_valid && clk_en;
    endsequence
    sequence s_pgm;
        cmd_valid && clk_en && otp_program_flag;
    endsequence
    a_resp_follows:
    assert property (s_taken |=> resp_valid) else $error("no response");
    a_resp_idle:
    assert property (!cmd_valid && clk_en |=> !resp_valid) else $error("stray response");
    a_prog_gated:
    assert property ((s_taken and !otp_program_flag) |=> !prog_valid) else $error("program without flag");
    a_unused_answer:
    assert property ((s_taken and cmd_nibble_location < 4'h6) |=> !prog_valid && resp_word[3:0] == device_bus_id)
        else $error("unused location answer");
    a_mirror_form:
    assert property ((s_taken and !otp_program_flag) |=> resp_word[11:4] == 8'h0f && resp_word[15:12] == resp_word[3:0])
        else $error("mirror answer form");
    a_prog_form:
    assert property (s_pgm |=> resp_word[11:8] == $past(cmd_nibble_location) && resp_word[7:4] == {2'b11,
        $past(bank_select)}) else $error("program answer form");
    a_busid_write:
    assert property ((s_taken and bank_select == 2'h1 && cmd_nibble_location == 4'h7)
        |=> device_bus_id == $past(cmd_data))
        else $error("bus id write");
    a_filter_write:
    assert property ((s_taken and bank_select == 2'h0 && cmd_nibble_location == 4'h8) |=> filter_select ==
        $past(cmd_data[3:2])) else $error("filter write");
    a_seal_write:
    assert property ((s_taken and bank_select == 2'h0 && cmd_nibble_location == 4'h7)
        |=> seal_bit == $past(cmd_data[3]))
        else $error("seal write");
endmodule // onw_decoder_checker
bind onw_nibble_write_decoder onw_decoder_checker u_chk (.sys_clk, .nrst, .clk_en, .cmd_valid, .cmd_nibble_location,
    .cmd_data, .bank_select, .otp_program_flag, .resp_valid, .resp_word, .prog_valid, .device_bus_id, .filter_select,
    .seal_bit);

// ==== onw_master_model.sv ====
// bus master model issuing nonvolatile write commands
`timescale 1ns/100ps
module onw_master_model (
    input wire logic sys_clk, // clock
    output logic cmd_valid, // command strobe
    output logic [3:0] cmd_nibble_location, // nibble location
    output logic [3:0] cmd_data, // data nibble
    output logic [1:0] bank_select, // bank level
    output logic otp_program_flag // program flag level
);
    // idle values before the first command
    initial begin
        cmd_valid = 1'b0;
        cmd_nibble_location = 4'h0;
        cmd_data = 4'h0;
        bank_select = 2'h0;
        otp_program_flag = 1'b0;
    end
    // bank and flag are set up with the command, strobe lasts one cycle
    task automatic send(input logic [1:0] b, input logic [3:0] l, input logic [3:0] d, input logic f);
        @(posedge sys_clk);
        #1;
        bank_select = b;
        otp_program_flag = f;
        cmd_nibble_location = l;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        // fields are dead now: invert so a stale value never passes
        cmd_nibble_location = ~l;
        cmd_data = ~d;
    endtask
endmodule // onw_master_model

// ==== onw_nibble_write_decoder.sv ====
// nonvolatile nibble write decoder with mirror copy and otp program port
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: unused locations: no write, answer bus identifier
// RULE2: bank0 loc7: only bit3 to seal bit
// RULE3: bank0 loc8: bits3:2 to filter select
// RULE4: bank0 loc9: check value plus spare bit
// RULE5: bank0 locA: identity bit plus spare bits
// RULE6: bank1 loc6: user byte0 low, aux trim
// RULE7: bank1 loc7: all bits to bus identifier
// RULE8: bank1 loc8-F: low nibble user bytes 1-8
// RULE9: bank2 loc6: user byte0 bits 5:2
// RULE10: bank2 loc7: only bit1 to spare mode
// RULE11: bank2 loc8-F: high nibble user bytes 1-8
// RULE12: bank3 loc7: only bit2 to ext2 bit6
// RULE13: bank3 locF: only bit0 to ext2 bit4
// RULE14: program array only with program flag set
// RULE15: programming answer: location, bank, readback
// RULE16: partial writes keep other byte bits
// RULE17: master picks bank first, reads back after; the master model sets bank_select in the same cycle as each command
module onw_nibble_write_decoder
    import onw_pkg::*;
#(
    parameter int NUM_BYTES = ONW_NUM_BYTES
) (
    input wire logic sys_clk,                       // system clock, 125 MHz
    input wire logic nrst,                          // async reset, active low
    input wire logic clk_en,                        // freezes all state except the reset release flops when low
    input wire logic cmd_valid,                     // one-cycle write command strobe
    input wire logic [3:0] cmd_nibble_location,     // nibble_location of the command
    input wire logic [3:0] cmd_data,                // data nibble of the command
    input wire logic [1:0] bank_select,             // bank chosen at initialization
    input wire logic otp_program_flag,              // program flag from initialization
    input wire logic load_valid,                    // mirror load strobe from otp array
    input wire logic [3:0] load_index,              // mirror byte being loaded
    input wire logic [7:0] load_data,               // mirror byte value
    input wire logic [3:0] mirror_rd_index,         // mirror byte to show
    output logic resp_valid,                        // one-cycle response strobe
    output logic [15:0] resp_word,                  // response data word
    output logic prog_valid,                        // one-cycle otp program request
    output logic [3:0] prog_index,                  // otp byte to program
    output logic [7:0] prog_mask,                   // bits of that byte to program
    output logic [7:0] prog_data,                   // bit values to program
    output logic [7:0] mirror_rd_data,              // mirror byte at mirror_rd_index
    output logic [1:0] filter_select,               // low-pass filter selection
    output logic [3:0] device_bus_id,               // device bus identifier
    output logic identity_option_bit,               // identity option
    output logic [2:0] user_check_value,            // user check value
    output logic seal_bit,                          // user area seal
    output logic spare_mode_bit,                    // spare mode bit
    output logic [1:0] aux_trim_field,              // auxiliary trim
    output logic [5:0] user_byte_0                  // user byte zero
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_sync;

    // release through two flops so all state leaves reset on one edge
    // not gated by clk_en, so reset can leave while the block is frozen
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // location decode
    // ----------------------------------------------------------------
    // location map by bank, locations 0..5 unused in every bank:
    //   bank0: 7 seal, 8 filter select, 9 check value, a identity option
    //   bank1: 6 user byte zero low and trim, 7 bus id, 8..f user bytes low
    //   bank2: 6 user byte zero high, 7 spare mode, 8..f user bytes high
    //   bank3: 7 ext2 bit 6, f ext2 bit 4
    //   bank1 and bank2 share byte 2 for location 6 and bytes 4..11
    //   every other location is unused and writes nothing
    // returns {hit, high nibble, byte index, write mask}
    function automatic logic [9:0] loc_decode(input logic [1:0] bank, input logic [3:0] loc);
        logic hit;
        logic hi;
        logic [3:0] idx;
        logic [3:0] msk;
        hit = 1'b1;
        hi = 1'b0;
        idx = ONW_IDX_FILTER;
        msk = ONW_MASK_ALL;
        case ({bank, loc})
            {ONW_BANK0, ONW_LOC_7}: begin
                idx = ONW_IDX_EXT2;
                hi = 1'b1;
                msk = ONW_MASK_B3;                  // see RULE2
            end
            {ONW_BANK0, ONW_LOC_8}: begin
                idx = ONW_IDX_FILTER;
                hi = 1'b1;
                msk = ONW_MASK_B32;                 // see RULE3
            end
            {ONW_BANK0, ONW_LOC_9}: begin
                idx = ONW_IDX_SETUP0;               // see RULE4
            end
            {ONW_BANK0, ONW_LOC_A}: begin
                idx = ONW_IDX_SETUP0;
                hi = 1'b1;                          // see RULE5
            end
            {ONW_BANK1, ONW_LOC_6}: begin
                idx = ONW_IDX_EXT1;                 // see RULE6
            end
            {ONW_BANK1, ONW_LOC_7}: begin
                idx = ONW_IDX_EXT2;                 // see RULE7
            end
            {ONW_BANK2, ONW_LOC_6}: begin
                idx = ONW_IDX_EXT1;
                hi = 1'b1;                          // see RULE9
            end
            {ONW_BANK2, ONW_LOC_7}: begin
                idx = ONW_IDX_EXT2;
                hi = 1'b1;
                msk = ONW_MASK_B1;                  // see RULE10
            end
            {ONW_BANK3, ONW_LOC_7}: begin
                idx = ONW_IDX_EXT2;
                hi = 1'b1;
                msk = ONW_MASK_B2;                  // see RULE12
            end
            {ONW_BANK3, ONW_LOC_F}: begin
                idx = ONW_IDX_EXT2;
                hi = 1'b1;
                msk = ONW_MASK_B0;                  // see RULE13
            end
            default: begin
                // user bytes 1..8 in ascending order of location
                if (loc[3] && (bank == ONW_BANK1 || bank == ONW_BANK2)) begin
                    idx = ONW_IDX_USER1 + {1'b0, loc[2:0]};   // see RULE8
                    hi = (bank == ONW_BANK2);                 // see RULE11
                end else begin
                    hit = 1'b0;                     // see RULE1
                end
            end
        endcase
        return {hit, hi, idx, msk};
    endfunction

    // place a nibble in the high or low half of a byte, zeros elsewhere
    function automatic logic [7:0] nib_place(input logic hi, input logic [3:0] nib);
        return hi ? {nib, 4'h0} : {4'h0, nib};
    endfunction

    // pick the high or low half of a byte
    function automatic logic [3:0] nib_pick(input logic hi, input logic [7:0] byte_in);
        return hi ? byte_in[7:4] : byte_in[3:0];
    endfunction

    // ----------------------------------------------------------------
    // write data path
    // ----------------------------------------------------------------
    logic [7:0] mirror_reg [NUM_BYTES];
    // target of the command: hit, half, byte, mask
    wire logic [9:0] dec = loc_decode(bank_select, cmd_nibble_location);
    wire logic dec_hit = dec[9];
    wire logic dec_hi = dec[8];
    wire logic [3:0] dec_index = dec[7:4];
    wire logic [3:0] dec_mask = dec[3:0];
    // commands count only while the enable is high
    wire logic take = clk_en & cmd_valid;
    wire logic do_write = take & dec_hit;

    // ----------------------------------------------------------------
    // nibble merge
    // ----------------------------------------------------------------
    // merge only masked bits so partial writes keep the rest of the byte
    wire logic [7:0] mask8 = nib_place(dec_hi, dec_mask);
    wire logic [7:0] data8 = nib_place(dec_hi, cmd_data);
    // read-modify-write on the mirror copy of the addressed byte
    wire logic [7:0] old_byte = mirror_reg[dec_index];
    wire logic [7:0] merged = (old_byte & ~mask8) | (data8 & mask8);   // see RULE16
    wire logic [3:0] merged_nib = nib_pick(dec_hi, merged);

    // a write to the identifier nibble answers with the new identifier
    wire logic id_write = dec_hit && dec_index == ONW_IDX_EXT2 && !dec_hi;
    wire logic [3:0] cur_id = mirror_reg[ONW_IDX_EXT2][ONW_BUSID_LSB +: 4];
    wire logic [3:0] new_id = id_write ? merged[3:0] : cur_id;

    // ----------------------------------------------------------------
    // response word
    // ----------------------------------------------------------------
    // layouts, high to low:
    //   programming: id, location, tag, bank, readback nibble
    //   mirror only: id, fixed middle pattern, id again
    // flag low: mirror-only answer, no array write
    // the id is the one after the write, so an id change answers new
    wire logic [3:0] rd_nib = dec_hit ? merged_nib : new_id;                  // see RULE1
    wire logic [15:0] resp_pgm = {new_id, cmd_nibble_location, ONW_RESP_PGM_TAG,
                                  bank_select, rd_nib};                       // see RULE15
    wire logic [15:0] resp_mir = {new_id, ONW_RESP_MIR_MID, new_id};
    wire logic [15:0] resp_next = otp_program_flag ? resp_pgm : resp_mir;    // see RULE14

    // ----------------------------------------------------------------
    // mirror storage
    // ----------------------------------------------------------------
    // byte map:
    //   0 filter_config_byte: filter select 7:6
    //   1 device_setup_0: check value 2:0, identity option 7
    //   2 device_setup_ext1: aux trim 1:0, user byte zero 7:2
    //   3 device_setup_ext2: bus id 3:0, spare mode 5, seal 7
    //   4..11 user_byte_1 .. user_byte_8

    // write enables, one bit per mirror byte
    wire logic [NUM_BYTES-1:0] byte_cmd_we;
    wire logic [NUM_BYTES-1:0] byte_load_we;

    // one enable pair per byte; a command write masks a load to the same byte
    for (genvar gi = 0; gi < NUM_BYTES; gi++) begin : g_byte_we
        assign byte_cmd_we[gi] = do_write && (dec_index == 4'(gi));
        assign byte_load_we[gi] = load_valid && (load_index == 4'(gi)) && !byte_cmd_we[gi];
    end

    // reset clears the mirror; the load port fills it from the otp array
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            for (int i = 0; i < NUM_BYTES; i++) begin
                mirror_reg[i] <= ONW_MIRROR_RESET;
            end
        end else if (clk_en) begin
            for (int i = 0; i < NUM_BYTES; i++) begin
                if (byte_cmd_we[i]) begin
                    mirror_reg[i] <= merged;        // see RULE14
                end else if (byte_load_we[i]) begin
                    mirror_reg[i] <= load_data;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // response and program request
    // ----------------------------------------------------------------
    // response strobe for every taken command, hit or not
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            resp_valid <= 1'b0;
            resp_word <= 16'h0000;
        end else if (clk_en) begin
            resp_valid <= cmd_valid;                      // see RULE15
            if (cmd_valid) begin
                resp_word <= resp_next;
            end
        end
    end

    // only masked bits are requested, so otp bits outside stay unburnt
    // held until the next command, valid with prog_valid
    wire logic [7:0] prog_mask_next = dec_hit ? mask8 : 8'h00;   // see RULE16
    wire logic [7:0] prog_data_next = data8 & prog_mask_next;
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            prog_valid <= 1'b0;
            prog_index <= 4'h0;
            prog_mask <= 8'h00;
            prog_data <= 8'h00;
        end else if (clk_en) begin
            prog_valid <= do_write & otp_program_flag;    // see RULE14
            if (cmd_valid) begin
                prog_index <= dec_index;
                prog_mask <= prog_mask_next;
                prog_data <= prog_data_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // mirror readout
    // ----------------------------------------------------------------
    // out-of-range index reads as zero rather than aliasing a real byte
    // registered: the readout trails its index by one cycle
    wire logic rd_in_range = mirror_rd_index < 4'(NUM_BYTES);
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            mirror_rd_data <= 8'h00;
        end else if (clk_en) begin
            mirror_rd_data <= rd_in_range ? mirror_reg[mirror_rd_index] : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // field views
    // ----------------------------------------------------------------
    // levels straight from the mirror flops, no extra delay
    assign filter_select = mirror_reg[ONW_IDX_FILTER][ONW_FILTER_SEL_LSB +: 2];
    assign device_bus_id = cur_id;
    assign identity_option_bit = mirror_reg[ONW_IDX_SETUP0][ONW_IDENT_BIT];
    assign user_check_value = mirror_reg[ONW_IDX_SETUP0][ONW_CHECK_LSB +: 3];
    assign seal_bit = mirror_reg[ONW_IDX_EXT2][ONW_SEAL_BIT];
    assign spare_mode_bit = mirror_reg[ONW_IDX_EXT2][ONW_SPARE_BIT];
    assign aux_trim_field = mirror_reg[ONW_IDX_EXT1][ONW_TRIM_LSB +: 2];
    assign user_byte_0 = mirror_reg[ONW_IDX_EXT1][ONW_UB0_LSB +: 6];

endmodule // onw_nibble_write_decoder

// ==== onw_pkg.sv ====
// constants for the otp nibble write decoder
package onw_pkg;

    // ----------------------------------------------------------------
    // mirror byte indices
    // ----------------------------------------------------------------
    localparam int ONW_NUM_BYTES = 12;
    localparam logic [3:0] ONW_IDX_FILTER = 4'h0;  // filter_config_byte
    localparam logic [3:0] ONW_IDX_SETUP0 = 4'h1;  // device_setup_0
    localparam logic [3:0] ONW_IDX_EXT1 = 4'h2;    // device_setup_ext1
    localparam logic [3:0] ONW_IDX_EXT2 = 4'h3;    // device_setup_ext2
    localparam logic [3:0] ONW_IDX_USER1 = 4'h4;   // user_byte_1, user bytes 2..8 follow
    localparam logic [7:0] ONW_MIRROR_RESET = 8'h00;

    // ----------------------------------------------------------------
    // field positions inside the mirror bytes
    // ----------------------------------------------------------------
    localparam int ONW_FILTER_SEL_LSB = 6;   // filter_config_byte[7:6]
    localparam int ONW_CHECK_LSB = 0;        // device_setup_0[2:0]
    localparam int ONW_IDENT_BIT = 7;        // device_setup_0[7]
    localparam int ONW_TRIM_LSB = 0;         // device_setup_ext1[1:0]
    localparam int ONW_UB0_LSB = 2;          // device_setup_ext1[7:2]
    localparam int ONW_BUSID_LSB = 0;        // device_setup_ext2[3:0]
    localparam int ONW_SPARE_BIT = 5;        // device_setup_ext2[5]
    localparam int ONW_SEAL_BIT = 7;         // device_setup_ext2[7]

    // ----------------------------------------------------------------
    // bank and nibble location codes
    // ----------------------------------------------------------------
    localparam logic [1:0] ONW_BANK0 = 2'h0;
    localparam logic [1:0] ONW_BANK1 = 2'h1;
    localparam logic [1:0] ONW_BANK2 = 2'h2;
    localparam logic [1:0] ONW_BANK3 = 2'h3;
    localparam logic [3:0] ONW_LOC_6 = 4'h6;
    localparam logic [3:0] ONW_LOC_7 = 4'h7;
    localparam logic [3:0] ONW_LOC_8 = 4'h8;
    localparam logic [3:0] ONW_LOC_9 = 4'h9;
    localparam logic [3:0] ONW_LOC_A = 4'ha;
    localparam logic [3:0] ONW_LOC_F = 4'hf;

    // ----------------------------------------------------------------
    // write masks within the addressed nibble
    // ----------------------------------------------------------------
    localparam logic [3:0] ONW_MASK_ALL = 4'hf;
    localparam logic [3:0] ONW_MASK_B3 = 4'h8;
    localparam logic [3:0] ONW_MASK_B32 = 4'hc;
    localparam logic [3:0] ONW_MASK_B2 = 4'h4;
    localparam logic [3:0] ONW_MASK_B1 = 4'h2;
    localparam logic [3:0] ONW_MASK_B0 = 4'h1;

    // ----------------------------------------------------------------
    // response word constants
    // ----------------------------------------------------------------
    localparam logic [1:0] ONW_RESP_PGM_TAG = 2'h3;   // bits 7:6 when programming
    localparam logic [7:0] ONW_RESP_MIR_MID = 8'h0f;  // bits 11:4 when mirror only

endpackage

// ==== tb_otp_nibble_write_decoder.sv ====
// self-checking testbench for the nibble write decoder
`timescale 1ns/100ps
module tb_otp_nibble_write_decoder
    import onw_pkg::*;
;
    logic sys_clk, nrst, clk_en, load_valid, cmd_valid, otp_program_flag, resp_valid, prog_valid;
    logic identity_option_bit, seal_bit, spare_mode_bit;
    logic [3:0] cmd_nibble_location, cmd_data, load_index, mirror_rd_index, prog_index, device_bus_id;
    logic [1:0] bank_select, filter_select, aux_trim_field;
    logic [7:0] load_data, prog_mask, prog_data, mirror_rd_data;
    logic [15:0] resp_word;
    logic [2:0] user_check_value;
    logic [5:0] user_byte_0;
    logic [7:0] mir [ONW_NUM_BYTES];
    int miscompares = 0;
    int checks_done = 0;
    onw_master_model u_master (.sys_clk, .cmd_valid, .cmd_nibble_location, .cmd_data, .bank_select, .otp_program_flag);
    onw_nibble_write_decoder uut (.sys_clk, .nrst, .clk_en, .cmd_valid, .cmd_nibble_location, .cmd_data,
        .bank_select, .otp_program_flag, .load_valid, .load_index, .load_data, .mirror_rd_index, .resp_valid,
        .resp_word, .prog_valid, .prog_index, .prog_mask, .prog_data, .mirror_rd_data, .filter_select,
        .device_bus_id, .identity_option_bit, .user_check_value, .seal_bit, .spare_mode_bit, .aux_trim_field,
        .user_byte_0);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // expected target: {used, high nibble, byte index, bit mask}
    function automatic logic [9:0] dec(input logic [1:0] b, input logic [3:0] l);
        if (l >= 4'h8 && b == 2'h1) return {2'b10, l - 4'h4, 4'hf};
        if (l >= 4'h8 && b == 2'h2) return {2'b11, l - 4'h4, 4'hf};
        case ({b, l})
            6'h07: return {2'b11, 4'h3, 4'h8};
            6'h08: return {2'b11, 4'h0, 4'hc};
            6'h09: return {2'b10, 4'h1, 4'hf};
            6'h0a: return {2'b11, 4'h1, 4'hf};
            6'h16: return {2'b10, 4'h2, 4'hf};
            6'h17: return {2'b10, 4'h3, 4'hf};
            6'h26: return {2'b11, 4'h2, 4'hf};
            6'h27: return {2'b11, 4'h3, 4'h2};
            6'h37: return {2'b11, 4'h3, 4'h4};
            6'h3f: return {2'b11, 4'h3, 4'h1};
            default: return 10'h000;
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // model the write first: the answer carries the state after it
    task automatic do_cmd(input logic [1:0] b, input logic [3:0] l, input logic [3:0] d, input logic f);
        logic [9:0] dc;
        logic [7:0] m8, d8;
        logic [3:0] id, rd;
        dc = dec(b, l);
        m8 = dc[8] ? {dc[3:0], 4'h0} : {4'h0, dc[3:0]};
        d8 = (dc[8] ? {d, 4'h0} : {4'h0, d}) & m8;
        if (dc[9]) mir[dc[7:4]] = (mir[dc[7:4]] & ~m8) | d8;
        id = mir[ONW_IDX_EXT2][3:0];
        rd = !dc[9] ? id : dc[8] ? mir[dc[7:4]][7:4] : mir[dc[7:4]][3:0];
        u_master.send(b, l, d, f);
        chk("resp_valid", 16'(resp_valid), 16'h1);
        chk("resp_word", resp_word, f ? {id, l, 2'b11, b, rd} : {id, 8'h0f, id});
        chk("prog_valid", 16'(prog_valid), 16'(dc[9] & f));
        chk("device_bus_id", 16'(device_bus_id), 16'(id));
        if (dc[9] & f) begin
            chk("prog_index", 16'(prog_index), 16'(dc[7:4]));
            chk("prog_mask_data", {prog_mask, prog_data}, {m8, d8});
        end
    endtask
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        load_valid = 1'b0;
        load_index = 4'h0;
        load_data = 8'h00;
        mirror_rd_index = 4'h0;
        void'($urandom(66962));
        repeat (6) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge sys_clk);
        // preload through the load port; the last index is out of range
        for (int i = 0; i <= ONW_NUM_BYTES; i++) begin
            #1;
            load_valid = 1'b1;
            load_index = 4'(i);
            load_data = 8'($urandom);
            if (i < ONW_NUM_BYTES) mir[i] = load_data;
            @(posedge sys_clk);
        end
        #1 load_valid = 1'b0;
        $display("test load done");
        // every bank and location, mirror form then program form
        for (int i = 0; i < 128; i++) do_cmd(2'(i >> 4), 4'(i), 4'($urandom), 1'(i >> 6));
        $display("test all locations done");
        for (int i = 0; i < 200; i++) do_cmd(2'($urandom), 4'($urandom), 4'($urandom), 1'($urandom));
        $display("test random done");
        // a load and a command to one byte in one cycle: the command wins
        load_valid = 1'b1;
        load_index = ONW_IDX_EXT2;
        load_data = 8'($urandom);
        mir[ONW_IDX_EXT2] = load_data;
        do_cmd(2'h1, 4'h7, ~load_data[3:0], 1'b0);
        load_valid = 1'b0;
        $display("test collision done");
        // a command while the enable is low is not taken
        @(posedge sys_clk);
        #1 clk_en = 1'b0;
        u_master.send(2'h1, 4'h7, 4'($urandom), 1'b1);
        chk("resp_gated", 16'(resp_valid), 16'h0);
        clk_en = 1'b1;
        $display("test enable done");
        for (int i = 0; i <= ONW_NUM_BYTES; i++) begin
            mirror_rd_index = 4'(i);
            @(posedge sys_clk);
            #1;
            chk("mirror_rd_data", 16'(mirror_rd_data), i < ONW_NUM_BYTES ? 16'(mir[i]) : 16'h0);
        end
        chk("views", {filter_select, user_check_value, identity_option_bit, seal_bit, spare_mode_bit, aux_trim_field,
            user_byte_0}, {mir[0][7:6], mir[1][2:0], mir[1][7], mir[3][7], mir[3][5], mir[2][1:0], mir[2][7:2]});
        $display("test readout done");
        results();
    end
    // about 700 cycles expected; cut off well beyond
    initial begin
        #(8 * 5000);
        miscompares++;
        $display("watchdog expired");
        results();
    end
endmodule // tb_otp_nibble_write_decoder
